//--- rtl/clc_pkg.sv
package clc_pkg;

    // Register map.
    localparam logic [7:0] CLC_CFG3_ADDR = 8'h8A;
    localparam logic [31:0] CLC_CFG3_RESET = 32'h14000000;

    // Field positions (low bit of each field).
    localparam int CLC_PARITY_BIT = 31;
    localparam int CLC_DEMAG_CNT_LSB = 29;
    localparam int CLC_DEMAG_UP_LSB = 27;
    localparam int CLC_DEMAG_LO_LSB = 25;
    localparam int CLC_SMP_LOW_LSB = 23;
    localparam int CLC_SMP_HIGH_LSB = 21;
    localparam int CLC_DUTY_LOW_LSB = 19;
    localparam int CLC_DUTY_HIGH_LSB = 17;
    localparam int CLC_FALL_LIM_LSB = 11;

    // Breakpoints of the falling-phase limit table.
    localparam logic [5:0] CLC_FALL_BRK1 = 6'h20;
    localparam logic [5:0] CLC_FALL_BRK2 = 6'h30;
    localparam logic [11:0] CLC_FALL_STEP1 = 12'h019;
    localparam logic [11:0] CLC_FALL_STEP2 = 12'h032;
    localparam logic [11:0] CLC_FALL_STEP3 = 12'h064;
    localparam logic [11:0] CLC_FALL_BASE2 = 12'h320;
    localparam logic [11:0] CLC_FALL_BASE3 = 12'h640;

    // Commutation method.
    typedef enum logic {
        CLC_CROSSING = 1'b0,
        CLC_INTEGRATION = 1'b1
    } clc_mode_t;

    // Consecutive demagnetisation samples: 2, 3, 4, 5.
    function automatic logic [2:0] clc_demag_count(input logic [1:0] code);
        case (code)
            2'h0: return 3'h2;
            2'h1: return 3'h3;
            2'h2: return 3'h4;
            default: return 3'h5;
        endcase
    endfunction

    // Upper bound drop below supply in mV: 90, 120, 150, 180.
    function automatic logic [15:0] clc_upper_drop(input logic [1:0] code);
        case (code)
            2'h0: return 16'h005A;
            2'h1: return 16'h0078;
            2'h2: return 16'h0096;
            default: return 16'h00B4;
        endcase
    endfunction

    // Lower bound in mV: 30, 60, 90, 120.
    function automatic logic [15:0] clc_lower_bound(input logic [1:0] code);
        case (code)
            2'h0: return 16'h001E;
            2'h1: return 16'h003C;
            2'h2: return 16'h005A;
            default: return 16'h0078;
        endcase
    endfunction

    // Samples per 30 degrees, low threshold: 3, 4, 6, 8.
    function automatic logic [7:0] clc_smp_low(input logic [1:0] code);
        case (code)
            2'h0: return 8'h03;
            2'h1: return 8'h04;
            2'h2: return 8'h06;
            default: return 8'h08;
        endcase
    endfunction

    // Samples per 30 degrees, high threshold: 4, 6, 8, 10.
    function automatic logic [7:0] clc_smp_high(input logic [1:0] code);
        case (code)
            2'h0: return 8'h04;
            2'h1: return 8'h06;
            2'h2: return 8'h08;
            default: return 8'h0A;
        endcase
    endfunction

    // Duty thresholds in percent: 12, 15, 18, 20.
    function automatic logic [6:0] clc_duty(input logic [1:0] code);
        case (code)
            2'h0: return 7'h0C;
            2'h1: return 7'h0F;
            2'h2: return 7'h12;
            default: return 7'h14;
        endcase
    endfunction

endpackage

//--- rtl/clc_config.sv
`timescale 1ns/1ps
`default_nettype none

module clc_config
    import clc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [7:0] samples_per_30deg,
    input wire logic [6:0] duty_pct,
    input wire logic demag_start,
    input wire logic [15:0] phase_mv,
    input wire logic [15:0] motor_supply_mv,
    output logic use_integration,
    output logic demag_done,
    output logic [11:0] falling_phase_integration_limit
);

    logic rst_meta_q;
    logic rst_sync_q;
    logic [31:0] cfg_d;
    logic [31:0] cfg_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    clc_mode_t mode_d;
    clc_mode_t mode_q;
    logic [2:0] demag_cnt_d;
    logic [2:0] demag_cnt_q;
    logic demag_done_d;
    logic demag_done_q;
    logic [11:0] fall_lim_d;
    logic [11:0] fall_lim_q;
    logic [1:0] demag_check_sample_count;
    logic [1:0] demag_check_upper_bound;
    logic [1:0] demag_check_lower_bound;
    logic [1:0] samples_to_crossing_threshold;
    logic [1:0] samples_to_integration_threshold;
    logic [1:0] duty_to_crossing_threshold;
    logic [1:0] duty_to_integration_threshold;
    logic [5:0] fall_code;
    logic [15:0] upper_mv;
    logic [15:0] lower_mv;
    logic in_window;
    logic go_crossing;
    logic go_integration;

    // Reset release passes two flip-flops; assertion stays asynchronous.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Field extraction from the stored word.
    assign demag_check_sample_count = cfg_q[CLC_DEMAG_CNT_LSB +: 2];
    assign demag_check_upper_bound = cfg_q[CLC_DEMAG_UP_LSB +: 2];
    assign demag_check_lower_bound = cfg_q[CLC_DEMAG_LO_LSB +: 2];
    assign samples_to_crossing_threshold = cfg_q[CLC_SMP_LOW_LSB +: 2];
    assign samples_to_integration_threshold = cfg_q[CLC_SMP_HIGH_LSB +: 2];
    assign duty_to_crossing_threshold = cfg_q[CLC_DUTY_LOW_LSB +: 2];
    assign duty_to_integration_threshold = cfg_q[CLC_DUTY_HIGH_LSB +: 2];
    assign fall_code = cfg_q[CLC_FALL_LIM_LSB +: 6];

    // Register port: a write to the word's address stores all 32 bits.
    always_comb
    begin
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        if (reg_wr_en && (reg_addr == CLC_CFG3_ADDR))
        begin
            cfg_d = reg_wdata;
        end
        if (reg_rd_en)
        begin
            if (reg_addr == CLC_CFG3_ADDR)
            begin
                rdata_d = cfg_q;
            end
            else
            begin
                rdata_d = 32'h00000000;
            end
        end
    end

    // Configuration storage and read data.
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            cfg_q <= CLC_CFG3_RESET;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // Method selection; both measures must agree before moving to integration.
    always_comb
    begin
        go_crossing = (samples_per_30deg < clc_smp_low(samples_to_crossing_threshold))
            || (duty_pct < clc_duty(duty_to_crossing_threshold));
        go_integration =
            (samples_per_30deg > clc_smp_high(samples_to_integration_threshold))
            && (duty_pct > clc_duty(duty_to_integration_threshold));
        mode_d = mode_q;
        if (sample_valid)
        begin
            case (mode_q)
                CLC_INTEGRATION:
                begin
                    if (go_crossing)
                    begin
                        mode_d = CLC_CROSSING;
                    end
                end
                default:
                begin
                    if (go_integration)
                    begin
                        mode_d = CLC_INTEGRATION;
                    end
                end
            endcase
        end
    end

    // Method register starts in zero-crossing mode.
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            mode_q <= CLC_CROSSING;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    // Demagnetisation window: phase strictly between lower and supply-minus-drop.
    always_comb
    begin
        upper_mv = motor_supply_mv - clc_upper_drop(demag_check_upper_bound);
        lower_mv = clc_lower_bound(demag_check_lower_bound);
        in_window = (motor_supply_mv > clc_upper_drop(demag_check_upper_bound))
            && (phase_mv < upper_mv) && (phase_mv > lower_mv);
        demag_cnt_d = demag_cnt_q;
        demag_done_d = demag_done_q;
        if (demag_start)
        begin
            demag_cnt_d = 3'h0;
            demag_done_d = 1'b0;
        end
        else if (sample_valid && !demag_done_q)
        begin
            if (!in_window)
            begin
                demag_cnt_d = 3'h0;
            end
            else if ((demag_cnt_q + 3'h1) >= clc_demag_count(demag_check_sample_count))
            begin
                demag_cnt_d = 3'h0;
                demag_done_d = 1'b1;
            end
            else
            begin
                demag_cnt_d = demag_cnt_q + 3'h1;
            end
        end
    end

    // Falling-phase limit decoded from the six-bit code.
    always_comb
    begin
        if (fall_code <= CLC_FALL_BRK1)
        begin
            fall_lim_d = 12'(fall_code) * CLC_FALL_STEP1;
        end
        else if (fall_code <= CLC_FALL_BRK2)
        begin
            fall_lim_d = CLC_FALL_BASE2 + 12'(fall_code - CLC_FALL_BRK1) * CLC_FALL_STEP2;
        end
        else
        begin
            fall_lim_d = CLC_FALL_BASE3 + 12'(fall_code - CLC_FALL_BRK2) * CLC_FALL_STEP3;
        end
    end

    // Demagnetisation counter and decoded limit registers.
    always_ff @(posedge core_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            demag_cnt_q <= 3'h0;
            demag_done_q <= 1'b0;
            fall_lim_q <= 12'h000;
        end
        else
        begin
            demag_cnt_q <= demag_cnt_d;
            demag_done_q <= demag_done_d;
            fall_lim_q <= fall_lim_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign use_integration = (mode_q == CLC_INTEGRATION);
    assign demag_done = demag_done_q;
    assign falling_phase_integration_limit = fall_lim_q;

endmodule // clc_config

`default_nettype wire

//--- testbench/clc_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module clc_config_chk
    import clc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [7:0] samples_per_30deg,
    input wire logic [6:0] duty_pct,
    input wire logic demag_start,
    input wire logic use_integration,
    input wire logic demag_done,
    input wire logic [11:0] falling_phase_integration_limit
);
    logic [1:0] up_q;
    logic [1:0] up_d;
    logic [5:0] lim_code;
    // Counts edges after release so that checks wait out the synchronised reset.
    always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            up_q <= 2'h0;
        else
            up_q <= up_d;
    assign lim_code = reg_wdata[16:11];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst || up_q != 2'h3);
    // A write of the word, and one whose limit code lies in the first table segment.
    sequence wr_s;
        reg_wr_en && reg_addr == CLC_CFG3_ADDR;
    endsequence
    sequence low_wr_s;
        wr_s ##0 !reg_wdata[16];
    endsequence
    // A read of the word with no write beside it.
    sequence rd_s;
        reg_rd_en && !reg_wr_en && reg_addr == CLC_CFG3_ADDR;
    endsequence
    rd_back_a: assert property (wr_s ##1 rd_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("read back differs");
    rd_other_a: assert property (reg_rd_en && reg_addr != CLC_CFG3_ADDR
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    lim_step_a: assert property (low_wr_s ##1 !reg_wr_en
        |=> falling_phase_integration_limit == {6'h0, $past(lim_code, 2)} * 12'h019)
        else $error("limit decode wrong");
    to_cross_a: assert property (sample_valid
        && (samples_per_30deg < 8'h03 || duty_pct < 7'h0C) |=> !use_integration)
        else $error("no switch to crossing");
    to_integ_a: assert property (sample_valid
        && samples_per_30deg > 8'h0A && duty_pct > 7'h14 |=> use_integration)
        else $error("no switch to integration");
    mode_hold_a: assert property (!sample_valid |=> $stable(use_integration))
        else $error("method changed without sample");
    done_clear_a: assert property (demag_start |=> !demag_done)
        else $error("done not cleared");
    done_rise_a: assert property ($rose(demag_done) |-> $past(sample_valid))
        else $error("done rose without sample");
endmodule // clc_config_chk
bind clc_config clc_config_chk u_chk (.*);
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import clc_pkg::*;
    logic core_clk, nrst, reg_wr_en, reg_rd_en, sample_valid, demag_start, want, m;
    logic use_integration, demag_done;
    logic [7:0] reg_addr, samples_per_30deg;
    logic [6:0] duty_pct;
    logic [31:0] reg_wdata, reg_rdata, w, o;
    logic [15:0] phase_mv, motor_supply_mv, lo, hi;
    logic [11:0] falling_phase_integration_limit, c;
    logic [33:0] e;
    logic [33:0] q[$];
    int failures, checked, sl, sh, dl, dh, ca, cb, cc, cd;
    int lt[4] = '{8'h03, 8'h04, 8'h06, 8'h08};
    int ht[4] = '{8'h04, 8'h06, 8'h08, 8'h0A};
    int dt[4] = '{8'h0C, 8'h0F, 8'h12, 8'h14};
    logic [15:0] lot[4] = '{16'h001E, 16'h003C, 16'h005A, 16'h0078};
    logic [15:0] drt[4] = '{16'h005A, 16'h0078, 16'h0096, 16'h00B4};
    int ct[6] = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h30, 8'h31};
    clc_config dut (.*);
    // Free-running core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Drives the strobes at the falling edge and clears any pending note.
    task automatic put(input logic [3:0] s, input logic [7:0] a);
        @(negedge core_clk);
        {reg_wr_en, reg_rd_en, sample_valid, demag_start} = s;
        reg_addr = a;
        want = 1'b0;
    endtask
    task automatic chk(input logic [1:0] sel, input logic [31:0] v);
        q.push_back({sel, v});
        want = 1'b1;
    endtask
    task automatic wr(input logic [31:0] d);
        put(4'h8, 8'h8A);
        reg_wdata = d;
    endtask
    // One sample; the method model follows the hysteresis.
    task automatic smp(input logic [7:0] s, input logic [6:0] d, input logic [15:0] p);
        put(4'h2, 8'h00);
        samples_per_30deg = s;
        duty_pct = d;
        phase_mv = p;
        if (s < sl || d < dl) m = 1'b0;
        else if (s > sh && d > dh) m = 1'b1;
    endtask
    function automatic logic [15:0] inw();
        return 16'(lo + 16'h1 + $urandom_range(hi - lo - 16'h2));
    endfunction
    // Takes the oldest note and compares it with the output after the edge.
    always @(posedge core_clk)
    begin
        if (want)
        begin
            e = q.pop_front();
            #1;
            case (e[33:32])
                2'h0: o = reg_rdata;
                2'h1: o = {31'h0, use_integration};
                2'h2: o = {31'h0, demag_done};
                default: o = {20'h0, falling_phase_integration_limit};
            endcase
            `CHK(o, e[31:0])
        end
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run of about 400 cycles.
    initial
    begin
        #500000;
        failures++;
        results();
    end
    // Main sequence.
    initial
    begin
        {nrst, want, m, reg_wr_en, reg_rd_en, sample_valid, demag_start} = 7'h0;
        {reg_addr, reg_wdata, samples_per_30deg, duty_pct, phase_mv} = 71'h0;
        motor_supply_mv = 16'h5DC0;
        w = $urandom(32'h0D11);
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) nrst = 1'b1;
        repeat (3) @(posedge core_clk);
        put(4'h4, 8'h8A);
        chk(0, 32'h14000000);
        put(4'h4, 8'h8B);
        chk(0, 32'h0);
        w = $urandom;
        wr(w);
        put(4'hC, 8'h8A);
        reg_wdata = ~w;
        chk(0, w);
        put(4'h4, 8'h8A);
        chk(0, ~w);
        put(4'h8, 8'h8B);
        reg_wdata = w;
        put(4'h4, 8'h8A);
        chk(0, ~w);
        $display("register test done");
        for (int i = 0; i < 8; i++)
        begin
            c = 12'((i < 6) ? ct[i] : $urandom_range(63));
            wr({w[31:17], c[5:0], w[10:0]});
            put(4'h0, 8'h00);
            chk(3, (c <= 12'h020) ? c * 12'h019 : (c <= 12'h030) ?
                12'h320 + (c - 12'h020) * 12'h032 : 12'h640 + (c - 12'h030) * 12'h064);
        end
        $display("limit test done");
        for (int i = 0; i < 12; i++)
        begin
            ca = $urandom_range(3);
            cb = ca + $urandom_range(3 - ca);
            cc = $urandom_range(3);
            cd = cc + $urandom_range(3 - cc);
            sl = lt[ca];
            sh = ht[cb];
            dl = dt[cc];
            dh = dt[cd];
            wr({w[31:25], ca[1:0], cb[1:0], cc[1:0], cd[1:0], w[16:0]});
            for (int j = 0; j < 20; j++)
            begin
                if (j < 16)
                    smp(8'(sl - 1 + j % 4), 7'(dh - 2 + j / 4), 16'h0);
                else
                    smp(8'($urandom_range(15)), 7'($urandom_range(30)), 16'h0);
                chk(1, {31'h0, m});
            end
        end
        $display("method test done");
        for (int i = 0; i < 8; i++)
        begin
            ca = $urandom_range(3);
            cb = $urandom_range(3);
            cc = $urandom_range(3);
            wr({w[31], ca[1:0], cb[1:0], cc[1:0], w[24:0]});
            motor_supply_mv = 16'(16'h2000 + $urandom_range(16'h4000));
            lo = lot[cc];
            hi = motor_supply_mv - drt[cb];
            put(4'h1, 8'h00);
            repeat (ca + 1) smp(8'h05, 7'h32, inw());
            smp(8'h05, 7'h32, i[0] ? hi : lo);
            repeat (ca + 1) smp(8'h05, 7'h32, inw());
            put(4'h0, 8'h00);
            chk(2, 32'h0);
            smp(8'h05, 7'h32, inw());
            put(4'h0, 8'h00);
            chk(2, 32'h1);
            put(4'h1, 8'h00);
            chk(2, 32'h0);
        end
        $display("demag test done");
        put(4'h0, 8'h00);
        put(4'h0, 8'h00);
        results();
    end
endmodule // tb_top
`default_nettype wire
